// ---- rtl/pcs_defines.svh ----
// constants for the pcs host port and clocking block
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define PCS_ADDR_W 5
`define PCS_DATA_W 16
`define PCS_NUM_REGS 32
`define PCS_BUSY_CYCLES 2'h2
`define PCS_DIV_100M 7'h0a
`define PCS_DIV_10M 7'h64
`define PCS_SPEED_10 2'h0
`define PCS_SPEED_100 2'h1
`define PCS_SPEED_1000 2'h2
`endif

// ---- rtl/pcs_device.sv ----
// device end: register port, resets and clock enablers of the pcs
// Notes on behaviour
// - host clocks register port at most 125 MHz
// - register reset clears all register-clock logic except the register array
// - host uses write and read strobes
// - five-bit address selects one 16-bit word
// - data buses 16 bits, bit 0 lsb
// - busy high during access, low completes
// - receive and transmit resets clear own logic
// - receive and transmit clocks run at 125 MHz; here both are core_clk_in, 100 MHz in the bench
// - transfers synchronous to their own clock
// - clock enables generated only in SGMII mode
// - enables gate active receive/transmit cycles
// - gigabit status always 1 in 1000BASE-X
`timescale 1ns/10ps
`include "pcs_defines.svh"
module pcs_device
  import pcs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic reset_rx_in,
  input wire logic reset_tx_in,
  input wire logic sgmii_mode_in,
  input wire logic [1:0] speed_in,
  pcs_if.device bus,
  output logic rx_clk_out,
  output logic tx_clk_out
);
  // one clock carries all domains here; the separate resets still isolate them
  logic [15:0] regs [0:`PCS_NUM_REGS-1];
  pcs_reg_state_t state, next_state;
  logic [1:0] cnt, next_cnt;
  logic [15:0] rdata, next_rdata;
  logic [6:0] rx_div, next_rx_div, tx_div, next_tx_div;
  logic rx_en, next_rx_en, tx_en, next_tx_en;
  logic gig;

  // divider terminal count for the selected speed
  function automatic logic [6:0] div_limit(input logic [1:0] spd);
    case (spd)
      `PCS_SPEED_100: div_limit = `PCS_DIV_100M - 7'h01;
      `PCS_SPEED_10: div_limit = `PCS_DIV_10M - 7'h01;
      default: div_limit = 7'h00;
    endcase
  endfunction

  assign gig = !sgmii_mode_in || (speed_in == `PCS_SPEED_1000);
  assign rx_clk_out = core_clk_in;
  assign tx_clk_out = core_clk_in;
  assign bus.reg_busy = (state != PCS_ST_IDLE) && (state != PCS_ST_DONE) ||
                        ((bus.reg_wr || bus.reg_rd) && state == PCS_ST_IDLE);
  assign bus.reg_rdata = rdata;
  assign bus.rx_clkena = rx_en;
  assign bus.tx_clkena = tx_en;
  assign bus.gigabit = gig;

  // access sequencer: busy for a fixed count, then one done cycle
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_rdata = rdata;
    case (state)
      PCS_ST_IDLE: begin
        if (bus.reg_wr || bus.reg_rd) begin
          next_state = PCS_ST_BUSY;
          next_cnt = `PCS_BUSY_CYCLES;
        end
      end
      PCS_ST_BUSY: begin
        if (cnt == 2'h1) begin
          next_state = PCS_ST_DONE;
          if (bus.reg_rd) begin
            next_rdata = regs[bus.reg_addr];
          end
        end
        next_cnt = cnt - 2'h1;
      end
      PCS_ST_DONE: next_state = PCS_ST_IDLE; // host drops strobe here
      default: next_state = PCS_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= PCS_ST_IDLE;
      cnt <= 2'h0;
      rdata <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rdata <= next_rdata;
    end
  end

  // register array written at the end of a write access; no reset so it maps to ram
  always_ff @(posedge core_clk_in) begin
    if (state == PCS_ST_BUSY && cnt == 2'h1 && bus.reg_wr) begin
      regs[bus.reg_addr] <= bus.reg_wdata;
    end
  end

  // receive and transmit enable dividers, one per domain, each with its own reset on the shared core_clk_in
  always_comb begin
    next_rx_div = rx_div;
    next_tx_div = tx_div;
    next_rx_en = 1'b1;
    next_tx_en = 1'b1;
    if (sgmii_mode_in && !gig) begin
      next_rx_div = (rx_div >= div_limit(speed_in)) ? 7'h00 : rx_div + 7'h01;
      next_tx_div = (tx_div >= div_limit(speed_in)) ? 7'h00 : tx_div + 7'h01;
      next_rx_en = (rx_div == 7'h00);
      next_tx_en = (tx_div == 7'h00);
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_div <= 7'h00;
      rx_en <= 1'b0;
    end else if (reset_rx_in) begin
      rx_div <= 7'h00;
      rx_en <= 1'b0;
    end else begin
      rx_div <= next_rx_div;
      rx_en <= next_rx_en;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_div <= 7'h00;
      tx_en <= 1'b0;
    end else if (reset_tx_in) begin
      tx_div <= 7'h00;
      tx_en <= 1'b0;
    end else begin
      tx_div <= next_tx_div;
      tx_en <= next_tx_en;
    end
  end
endmodule

// ---- rtl/pcs_host.sv ----
// host end: register master and mac-side enable sampling
`timescale 1ns/10ps
`include "pcs_defines.svh"
module pcs_host
  import pcs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [4:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  output logic req_ready_out,
  output logic resp_valid_out,
  output logic [15:0] resp_rdata_out,
  input wire logic [7:0] tx_byte_in,
  output logic [7:0] tx_byte_out,
  output logic tx_strobe_out,
  output logic gigabit_out,
  pcs_if.host bus
);
  // core_clk_in stands in for the register clock, 100 MHz in the bench, within the 125 MHz limit
  pcs_reg_state_t state, next_state;
  logic wr, next_wr, rd, next_rd;
  logic [4:0] addr, next_addr;
  logic [15:0] wdata, next_wdata, rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic [7:0] txb, next_txb;
  logic txs, next_txs;

  assign bus.reg_wr = wr;
  assign bus.reg_rd = rd;
  assign bus.reg_addr = addr;
  assign bus.reg_wdata = wdata;
  assign req_ready_out = (state == PCS_ST_IDLE);
  assign resp_valid_out = rvalid;
  assign resp_rdata_out = rdata;
  assign tx_byte_out = txb;
  assign tx_strobe_out = txs;
  assign gigabit_out = bus.gigabit;

  // hold strobe until busy drops, then end the access
  always_comb begin
    next_state = state;
    next_wr = wr;
    next_rd = rd;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    case (state)
      PCS_ST_IDLE: begin
        if (req_valid_in) begin
          next_state = PCS_ST_BUSY;
          next_wr = req_write_in;
          next_rd = !req_write_in;
          next_addr = req_addr_in;
          next_wdata = req_wdata_in;
        end
      end
      PCS_ST_BUSY: begin
        if (!bus.reg_busy) begin
          next_state = PCS_ST_IDLE;
          next_wr = 1'b0;
          next_rd = 1'b0;
          next_rvalid = 1'b1;
          if (rd) begin
            next_rdata = bus.reg_rdata;
          end
        end
      end
      default: next_state = PCS_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= PCS_ST_IDLE;
      wr <= 1'b0;
      rd <= 1'b0;
      addr <= 5'h00;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      state <= next_state;
      wr <= next_wr;
      rd <= next_rd;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // mac transmit side: drive a new byte only on enabled cycles
  always_comb begin
    next_txb = txb;
    next_txs = 1'b0;
    if (bus.tx_clkena) begin
      next_txb = tx_byte_in;
      next_txs = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      txb <= 8'h00;
      txs <= 1'b0;
    end else begin
      txb <= next_txb;
      txs <= next_txs;
    end
  end
endmodule

// ---- rtl/pcs_if.sv ----
// interface joining the pcs device end and its host end
`timescale 1ns/10ps
interface pcs_if;
  logic reg_wr;
  logic reg_rd;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_busy;
  logic rx_clkena;
  logic tx_clkena;
  logic gigabit;
  modport device (
    input reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_busy, rx_clkena, tx_clkena, gigabit
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    input reg_rdata, reg_busy, rx_clkena, tx_clkena, gigabit
  );
endinterface

// ---- rtl/pcs_pkg.sv ----
// types shared by both ends of the pcs host port
package pcs_pkg;
  typedef enum logic [1:0] {
    PCS_ST_IDLE,
    PCS_ST_BUSY,
    PCS_ST_DONE
  } pcs_reg_state_t;
endpackage

// ---- sim/pcs_monitor.sv ----
// assertions on the interface joining the pcs device and host ends
`timescale 1ns/10ps
module pcs_monitor (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic reset_rx_in,
  input wire logic reset_tx_in,
  input wire logic sgmii_mode_in,
  input wire logic [1:0] speed_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_busy,
  input wire logic rx_clkena,
  input wire logic tx_clkena,
  input wire logic gigabit
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // register port handshake
  AST_BUSY_RISE: assert property ($rose(reg_wr || reg_rd) |-> reg_busy)
    else $error("busy not raised at access start");
  AST_BUSY_LEN: assert property ($rose(reg_busy) |-> reg_busy [*3] ##1 !reg_busy)
    else $error("busy length wrong");
  AST_BUSY_IDLE: assert property (!(reg_wr || reg_rd) |-> !reg_busy)
    else $error("busy without access");
  // gigabit status follows mode and speed
  AST_GIG_BASEX: assert property (!sgmii_mode_in |-> gigabit)
    else $error("gigabit low in base-x");
  AST_GIG_SGMII: assert property (sgmii_mode_in |-> gigabit == (speed_in == 2'h2))
    else $error("gigabit wrong in sgmii");
  // enables: the flops need one settled cycle after any reset or mode change
  AST_ENA_FULL: assert property (disable iff (!reset_n_in || reset_rx_in || reset_tx_in)
    (!sgmii_mode_in || speed_in == 2'h2) && $stable(speed_in) && $stable(sgmii_mode_in)
    && $past(reset_n_in) && !$past(reset_rx_in || reset_tx_in) |-> rx_clkena && tx_clkena)
    else $error("enable not steady at gigabit");
  AST_RX_100M: assert property (disable iff (!reset_n_in || reset_rx_in)
    sgmii_mode_in && speed_in == 2'h1 && $rose(rx_clkena)
    |=> !rx_clkena [*8] ##1 !rx_clkena ##1 rx_clkena) else $error("rx enable cadence wrong");
  AST_TX_100M: assert property (disable iff (!reset_n_in || reset_tx_in)
    sgmii_mode_in && speed_in == 2'h1 && $rose(tx_clkena)
    |=> !tx_clkena [*8] ##1 !tx_clkena ##1 tx_clkena) else $error("tx enable cadence wrong");
endmodule

// ---- sim/tb.sv ----
// self-checking bench joining the pcs device end to the host end
`timescale 1ns/10ps
module tb;
  logic core_clk_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic rrx = 1'h0, rtx = 1'h0, sg = 1'h0, vld = 1'h0, wr = 1'h0;
  logic rdy, rv, txs, gig, rxc, txc;
  logic [1:0] sp = 2'h0;
  logic [4:0] ad = 5'h00;
  logic [15:0] wd = 16'h0000, rd;
  logic [7:0] txo;
  int num_errors = 0, total_checks = 0;
  pcs_if bus ();
  always #5 core_clk_in = ~core_clk_in;
  pcs_device i_pcs_device (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .reset_rx_in(rrx),
    .reset_tx_in(rtx), .sgmii_mode_in(sg), .speed_in(sp), .bus(bus), .rx_clk_out(rxc),
    .tx_clk_out(txc));
  pcs_host i_pcs_host (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .req_valid_in(vld),
    .req_write_in(wr), .req_addr_in(ad), .req_wdata_in(wd), .req_ready_out(rdy),
    .resp_valid_out(rv), .resp_rdata_out(rd), .tx_byte_in(8'h5a), .tx_byte_out(txo),
    .tx_strobe_out(txs), .gigabit_out(gig), .bus(bus));
  pcs_monitor i_pcs_monitor (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .reset_rx_in(rrx), .reset_tx_in(rtx), .sgmii_mode_in(sg), .speed_in(sp),
    .reg_wr(bus.reg_wr), .reg_rd(bus.reg_rd), .reg_busy(bus.reg_busy),
    .rx_clkena(bus.rx_clkena), .tx_clkena(bus.tx_clkena), .gigabit(bus.gigabit));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      num_errors++;
      $display("FAIL %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  // one host request, held for the edge that takes it, then a bounded wait for the answer
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
    output logic [15:0] q);
    int n;
    @(negedge core_clk_in);
    chk_val(rdy, 16'h0001);
    vld = 1'h1;
    wr = w;
    ad = a;
    wd = d;
    @(negedge core_clk_in);
    vld = 1'h0;
    n = 0;
    while (rv !== 1'h1 && n < 20) begin
      @(negedge core_clk_in);
      n++;
    end
    if (rv !== 1'h1) begin
      num_errors++;
      tally_and_finish();
    end
    q = rd;
  endtask
  // neighbouring words and both end addresses must not alias
  task automatic t_regs();
    logic [4:0] a[4] = '{5'h00, 5'h01, 5'h1f, 5'h0a};
    logic [15:0] d[4] = '{16'h0001, 16'h8000, 16'ha5c3, 16'h5a3c};
    logic [15:0] q;
    for (int i = 0; i < 4; i++) acc(1'h1, a[i], d[i], q);
    for (int i = 0; i < 4; i++) begin
      acc(1'h0, a[i], 16'h0000, q);
      chk_val(q, d[i]);
    end
    $display("test regs done");
  endtask
  // a full window of 100 cycles holds an exact pulse count whatever the divider phase
  task automatic t_speed(input logic s, input logic [1:0] v, input int e, input logic g);
    int nr, nt, ns;
    nr = 0;
    nt = 0;
    ns = 0;
    @(negedge core_clk_in);
    rrx = 1'h1;
    rtx = 1'h1;
    sg = s;
    sp = v;
    repeat (2) @(negedge core_clk_in);
    rrx = 1'h0;
    rtx = 1'h0;
    repeat (4) @(negedge core_clk_in);
    repeat (100) begin
      @(negedge core_clk_in);
      nr += bus.rx_clkena;
      nt += bus.tx_clkena;
      ns += txs;
    end
    chk_cnt(nr, e);
    chk_cnt(nt, e);
    chk_cnt(ns, e);
    chk_val({8'h00, txo}, 16'h005a);
    chk_val(gig, g);
    @(posedge core_clk_in);
    #1;
    chk_val({rxc, txc}, 16'h0003);
    $display("test speed done");
  endtask
  // async reset in mid-access must drop busy and free the host at once
  task automatic t_reset();
    @(negedge core_clk_in);
    vld = 1'h1;
    wr = 1'h0;
    ad = 5'h1f;
    @(negedge core_clk_in);
    vld = 1'h0;
    @(negedge core_clk_in);
    chk_val(bus.reg_busy, 16'h0001);
    reset_n_in = 1'h0;
    #1;
    chk_val({bus.reg_busy, rdy}, 16'h0001);
    @(negedge core_clk_in);
    reset_n_in = 1'h1;
    repeat (2) @(negedge core_clk_in);
    $display("test reset done");
  endtask
  initial begin
    repeat (16) @(negedge core_clk_in);
    reset_n_in = 1'h1;
    t_regs();
    t_speed(1'h0, 2'h0, 100, 1'h1);
    t_speed(1'h1, 2'h2, 100, 1'h1);
    t_speed(1'h1, 2'h1, 10, 1'h0);
    t_speed(1'h1, 2'h0, 1, 1'h0);
    t_reset();
    tally_and_finish();
  end
endmodule
